// >>> include/at_cmd_map.svh
// Offsets, result codes, register indices and defaults of the command interpreter
`ifndef AT_CMD_MAP_SVH
`define AT_CMD_MAP_SVH
// AXI4-Lite byte offsets
`define A_CTRL 8'h00
`define A_STAT 8'h04
`define A_SEL 8'h08
`define A_DATA 8'h0c
`define RESP_OK 2'b00
`define RESP_ERR 2'b10
// Numbered result codes
`define RC_OK 7'h00
`define RC_CONN 7'h01
`define RC_RING 7'h02
`define RC_NOCAR 7'h03
`define RC_ERR 7'h04
`define RC_NODT 7'h06
`define RC_BUSY 7'h07
`define RC_NOANS 7'h08
`define RC_DELAY 7'h58
`define RC_BLK 7'h59
`define RC_BLKF 7'h5a
`define RC_TWO 7'h0a
// Parameter register indices and factory values
`define I_ESC 4'h2
`define I_RET 4'h3
`define I_LF 4'h4
`define I_BS 4'h5
`define I_VERB 4'he
`define D_ESC 8'h2b
`define D_RET 8'h0d
`define D_LF 8'h0a
`define D_BS 8'h08
`define D_VERB 8'h01
`define MAX_CHR 8'h7f
`define MAX_FLAG 8'h01
`define MAX_BYTE 8'hff
// Line and message layout
`define LINE_MAX 80
`define NREG 16
`define AT_LEN 7'h02
`define VAL_DIGITS 4'h3
`define SEG_LAST 3'h4
`define R_EXT_LAST 5'h0c
`define CASE_BIT 8'h20
`endif

// >>> include/at_cmd_pkg.sv
// Types shared by the command interpreter and its bench
package at_cmd_pkg;
  typedef enum logic [3:0] {EV_CONN, EV_RING, EV_NOCAR, EV_NODT, EV_BUSY, EV_NOANS,
                            EV_DELAY, EV_BLK, EV_BLKF} ev_kind_t;
  typedef enum logic [2:0] {EC_V42B, EC_V42, EC_C5, EC_C4, EC_NONE} ec_t;
  typedef struct packed {
    ev_kind_t kind;
    logic [4:0] rate;
    ec_t ec;
  } ev_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_EMIT = 2'b11} st_t;
  typedef enum logic [1:0] {PS_CMD = 2'b00, PS_NUM = 2'b01, PS_VAL = 2'b11, PS_AMP = 2'b10} ps_t;
endpackage : at_cmd_pkg

// >>> tb/host_term.sv
// Host terminal model: command characters out, reply characters in
`timescale 1ns/1ps
`default_nettype none
module host_term (
  input wire logic aclk, // Clock
  output logic rx_valid, // Char valid
  output logic [7:0] rx_data, // Char
  input wire logic rx_ready, // Char taken
  input wire logic tx_valid, // Reply valid
  input wire logic [7:0] tx_data, // Reply char
  output logic tx_ready // Reply taken
);
  byte unsigned lineq[$]; // Pending line chars
  byte unsigned rxq[$]; // Replies seen
  int seed = 7;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end
  // Lines open with the attention pair, except the XT error case, and carry decimal values
  always @(posedge aclk) begin
    if (tx_valid && tx_ready) rxq.push_back(tx_data);
    tx_ready <= ($random(seed) % 3) != 0; // Stalls like a slow terminal
    if (!rx_valid || rx_ready) begin
      rx_valid <= lineq.size() > 0;
      rx_data <= (lineq.size() > 0) ? lineq.pop_front() : ~rx_data; // Idle data toggles
    end
  end
endmodule : host_term
`default_nettype wire

// >>> tb/testbench.sv
// Bench for the command interpreter: registers, command lines, result codes
`timescale 1ns/1ps
`default_nettype none
`include "at_cmd_map.svh"
module testbench;
  import at_cmd_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid, awready, wready, arready;
  logic rx_valid, rx_ready, tx_valid, tx_ready, ev_valid, ev_ready;
  logic [7:0] awaddr, araddr, rx_data, tx_data;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  ev_t ev;
  int n_mismatch = 0, check_count = 0, seed = 7, v;
  int rt[18] = '{300, 1200, 2400, 4800, 7200, 9600, 12000, 14400, 16800, 19200, 21600, 24000, 26400, 28800,
    31200, 33600, 45000, 56000};
  int rc[18] = '{40, 5, 10, 11, 24, 12, 25, 13, 86, 14, 55, 56, 57, 58, 59, 60, 1, 1};
  int cd[9] = '{1, 2, 3, 6, 7, 8, 88, 89, 90};
  string wd[9] = '{"CONNECT", "RING", "NO CARRIER", "NO DIALTONE", "BUSY", "NO ANSWER", "DELAYED", "BLACKLISTED",
    "BLACKLIST FULL"};
  string s;
  string tg[5] = '{"/V42bis", "/V42", string'(40'h2f4d4e5035), string'(40'h2f4d4e5034), string'(40'h2f4e6f4543)};
  at_cmd_interp at_cmd_interp_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .rx_valid, .rx_data,
    .rx_ready, .tx_valid, .tx_data, .tx_ready, .ev_valid, .ev, .ev_ready);
  host_term host_term_i (.aclk, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic complete_run(input bit hung);
    if (hung) n_mismatch++;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Reply text compare; waits bounded for the whole reply
  task automatic check_str(input string exp);
    string got = "";
    for (int k = 0; k < 4000 && host_term_i.rxq.size() < exp.len(); k++) @(posedge aclk);
    if (host_term_i.rxq.size() < exp.len()) complete_run(1'b1);
    repeat (exp.len()) got = {got, string'(host_term_i.rxq.pop_front())};
    check_count++;
    if (got != exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_str
  task automatic line(input string l, input string exp);
    foreach (l[i]) host_term_i.lineq.push_back(l[i]);
    check_str(exp);
  endtask : line
  task automatic event_tx(input ev_kind_t k, input logic [4:0] r, input ec_t e, input string exp);
    int n;
    ev_valid <= 1'b1;
    ev <= '{k, r, e};
    for (n = 0; n < 4000; n++) begin
      @(posedge aclk);
      if (ev_ready) break;
    end
    if (n == 4000) complete_run(1'b1);
    ev_valid <= 1'b0;
    ev <= ev_t'(~ev); // Released payload must not be trusted
    check_str(exp);
  endtask : event_tx
  // Address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    {awvalid, wvalid, bready} <= 3'h7;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 100) complete_run(1'b1);
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, er});
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 100) complete_run(1'b1);
    rready <= 1'b0;
    check({30'h0, rresp}, {30'h0, er});
    check(rdata, ed);
  endtask : axi_rd
  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, ev_valid} = 7'h00;
    {awaddr, araddr, wdata, wstrb, ev} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_wr(`A_SEL, 32'h3, `RESP_OK);
    axi_rd(`A_DATA, 32'hd, `RESP_OK);
    axi_wr(8'h10, 32'h1, `RESP_ERR);
    axi_rd(8'h10, 32'h0, `RESP_ERR);
    v = {$random(seed)} % 256;
    line($sformatf("ATS7=%0dS7?Q\010\r", v), $sformatf("%03d\r\nOK\r\n", v));
    line("ATS3=200\r", "ERROR\r\n");
    line("ATS3?S16=1\r", "013\r\nERROR\r\n");
    line("XT\r", "ERROR\r\n");
    s = "AT";
    repeat (85) s = {s, " "};
    line({s, "\r"}, "ERROR\r\n");
    line($sformatf("ATS7=%0d&W0S7=1\r", v), "OK\r\n");
    line("AT&FS7?\r", "000\r\nOK\r\n");
    line("ATZS7?\r", $sformatf("%03d\r\nOK\r\n", v));
    axi_wr(`A_SEL, 32'h7, `RESP_OK);
    axi_rd(`A_DATA, v, `RESP_OK);
    foreach (cd[i]) event_tx(ev_kind_t'(i), 5'h00, EC_NONE, {wd[i], "\r\n"});
    axi_wr(`A_CTRL, 32'h1, `RESP_OK);
    axi_rd(`A_CTRL, 32'h1, `RESP_OK);
    foreach (rt[i]) begin
      v = {$random(seed)} % 5;
      s = (i > 11) ? "" : tg[v]; // Suffix only up to 24000
      event_tx(EV_CONN, 5'(i + 1), ec_t'(v), $sformatf("CONNECT %0d%s\r\n", rt[i], s));
    end
    line("ATS14=0\r", "0\r\n");
    foreach (rc[i]) event_tx(EV_CONN, 5'(i + 1), ec_t'({$random(seed)} % 5), $sformatf("%0d\r\n", rc[i]));
    foreach (cd[i]) event_tx(ev_kind_t'(i), 5'h00, EC_NONE, $sformatf("%0d\r\n", cd[i]));
    line("ATS99?\r", "4\r\n");
    complete_run(1'b0);
  end
endmodule : testbench
`default_nettype wire

// >>> verilog/at_cmd_interp.sv
// Command line interpreter with parameter registers, profile store and result codes
// What this block does
// (RULE_01) A register read replies with the value as three zero padded decimal digits.
// (RULE_02) A register assignment parses the decimal value and writes the active register.
// (RULE_03) The host gives character settings as decimal codes, never as characters.
// (RULE_04) Several commands in one line run left to right; reads see earlier writes.
// (RULE_05) Store-profile copies all active settings into nonvolatile memory.
// (RULE_06) With a stored profile, reload takes active settings from nonvolatile memory.
// (RULE_07) Factory restore loads the fixed default set, ignoring nonvolatile memory.
// (RULE_08) Store after assignments in one line saves the already updated values.
// (RULE_09) Every command line begins with the attention characters A and T.
// (RULE_10) A line without error answers result 0, OK, then awaits another line.
// (RULE_11) Too many or invalid characters answer result 4, ERROR.
// (RULE_12) Going online without a rate message answers result 1, CONNECT.
// (RULE_13) An incoming ring answers result 2, RING.
// (RULE_14) No carrier within the wait answers result 3, NO CARRIER.
// (RULE_15) Call failures answer 6 NO DIALTONE, 7 BUSY, 8 NO ANSWER.
// (RULE_16) Rate connects 300 to 19200 carry their own numbered CONNECT codes.
// (RULE_17) Rates 21600 to 33600 take codes 55 to 60; 45000 and 56000 are worded only.
// (RULE_18) Dial restrictions answer 88 DELAYED, 89 BLACKLISTED, 90 BLACKLIST FULL.
// (RULE_19) With the extended option, rate connects 300 to 24000 get an error-control suffix.
// (RULE_20) The suffix names compression, correction, class tags or the none tag.
// (RULE_21) Up to 80 line characters are buffered; backspace edits before the terminator.
// (RULE_22) The terminator is the return-character register, default 13, range 0 to 127.
// (RULE_23) Out of range values or unknown registers leave registers unchanged and give ERROR.
// (RULE_24) Terse or verbose result form follows a setting in the active profile.
`timescale 1ns/1ps
`default_nettype none
`include "at_cmd_map.svh"
module at_cmd_interp #(
  parameter int LINE_LEN = `LINE_MAX, // Line buffer depth
  parameter int NREG = `NREG // Parameter register count
) (
  input wire logic aclk, // System clock, 20 MHz
  input wire logic aresetn, // Synchronous reset, low
  input wire logic [7:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [7:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  input wire logic rx_valid, // Host character valid
  input wire logic [7:0] rx_data, // Host character
  output logic rx_ready, // Character taken
  output logic tx_valid, // Reply character valid
  output logic [7:0] tx_data, // Reply character
  input wire logic tx_ready, // Reply character taken
  input wire logic ev_valid, // Line event valid
  input wire at_cmd_pkg::ev_t ev, // Line event kind, rate, protocol
  output logic ev_ready // Event taken
);
  import at_cmd_pkg::*;
  localparam int IW = $clog2(NREG);

  // Uppercase fold so commands work in either case
  function automatic logic [7:0] up(input logic [7:0] ch);
    up = (ch >= "a" && ch <= "z") ? (ch & ~`CASE_BIT) : ch;
  endfunction : up

  function automatic logic [7:0] dchar(input logic [3:0] d);
    dchar = "0" | {4'h0, d};
  endfunction : dchar

  // Factory profile, held as a constant image
  function automatic logic [NREG-1:0][7:0] fact();
    fact = '0;
    fact[`I_ESC] = `D_ESC;
    fact[`I_RET] = `D_RET;
    fact[`I_LF] = `D_LF;
    fact[`I_BS] = `D_BS;
    fact[`I_VERB] = `D_VERB;
  endfunction : fact
  localparam logic [NREG-1:0][7:0] FACT_VEC = fact();

  // Permitted upper bound of each register
  function automatic logic [7:0] rmax(input logic [IW-1:0] i);
    case (i)
      `I_RET, `I_LF, `I_BS: rmax = `MAX_CHR;
      `I_VERB: rmax = `MAX_FLAG;
      default: rmax = `MAX_BYTE;
    endcase
  endfunction : rmax

  // Rate index to numbered code and decimal digits
  function automatic logic [26:0] rate_tab(input logic [4:0] r);
    case (r)
      5'h01: rate_tab = {7'h28, 20'h00300}; // [RULE_16]
      5'h02: rate_tab = {7'h05, 20'h01200};
      5'h03: rate_tab = {7'h0a, 20'h02400};
      5'h04: rate_tab = {7'h0b, 20'h04800};
      5'h05: rate_tab = {7'h18, 20'h07200};
      5'h06: rate_tab = {7'h0c, 20'h09600};
      5'h07: rate_tab = {7'h19, 20'h12000};
      5'h08: rate_tab = {7'h0d, 20'h14400};
      5'h09: rate_tab = {7'h56, 20'h16800};
      5'h0a: rate_tab = {7'h0e, 20'h19200};
      5'h0b: rate_tab = {7'h37, 20'h21600}; // [RULE_17]
      5'h0c: rate_tab = {7'h38, 20'h24000};
      5'h0d: rate_tab = {7'h39, 20'h26400};
      5'h0e: rate_tab = {7'h3a, 20'h28800};
      5'h0f: rate_tab = {7'h3b, 20'h31200};
      5'h10: rate_tab = {7'h3c, 20'h33600};
      5'h11: rate_tab = {`RC_CONN, 20'h45000}; // Worded only
      5'h12: rate_tab = {`RC_CONN, 20'h56000};
      default: rate_tab = {`RC_CONN, 20'h00000}; // [RULE_12]
    endcase
  endfunction : rate_tab

  function automatic logic [6:0] ev_code(input ev_kind_t k, input logic [6:0] rc);
    case (k)
      EV_CONN: ev_code = rc;
      EV_RING: ev_code = `RC_RING; // [RULE_13]
      EV_NOCAR: ev_code = `RC_NOCAR; // [RULE_14]
      EV_NODT: ev_code = `RC_NODT; // [RULE_15]
      EV_BUSY: ev_code = `RC_BUSY;
      EV_NOANS: ev_code = `RC_NOANS;
      EV_DELAY: ev_code = `RC_DELAY; // [RULE_18]
      EV_BLK: ev_code = `RC_BLK;
      EV_BLKF: ev_code = `RC_BLKF;
      default: ev_code = `RC_ERR;
    endcase
  endfunction : ev_code

  // Verbose words, right aligned, with their length
  function automatic logic [131:0] word(input logic [6:0] rc);
    case (rc)
      `RC_OK: word = {4'h2, 128'("OK")};
      `RC_RING: word = {4'h4, 128'("RING")};
      `RC_NOCAR: word = {4'ha, 128'("NO CARRIER")};
      `RC_ERR: word = {4'h5, 128'("ERROR")};
      `RC_NODT: word = {4'hb, 128'("NO DIALTONE")};
      `RC_BUSY: word = {4'h4, 128'("BUSY")};
      `RC_NOANS: word = {4'h9, 128'("NO ANSWER")};
      `RC_DELAY: word = {4'h7, 128'("DELAYED")};
      `RC_BLK: word = {4'hb, 128'("BLACKLISTED")};
      `RC_BLKF: word = {4'he, 128'("BLACKLIST FULL")};
      default: word = {4'h7, 128'("CONNECT")};
    endcase
  endfunction : word

  // Error-control suffix text
  function automatic logic [67:0] tag(input ec_t e);
    case (e)
      EC_V42B: tag = {4'h7, 64'("/V42bis")}; // [RULE_20]
      EC_V42: tag = {4'h4, 64'("/V42")};
      EC_C5: tag = {4'h5, 64'h2f4d4e5035};
      EC_C4: tag = {4'h5, 64'h2f4d4e5034};
      default: tag = {4'h5, 64'h2f4e6f4543};
    endcase
  endfunction : tag

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = a == `A_CTRL || a == `A_STAT || a == `A_SEL || a == `A_DATA;
  endfunction : addr_ok

  logic [NREG-1:0][7:0] act_r, nv_r;
  logic nv_valid_r, ext_en_r;
  logic [IW-1:0] sel_r;
  logic [7:0] line_r [LINE_LEN];
  logic [6:0] len_r, pos_r;
  logic ovf_r, wz_r;
  st_t st_r;
  ps_t ps_r;
  logic [7:0] num_r, vout_r;
  logic [11:0] val_r;
  logic [2:0] seg_r;
  logic [3:0] idx_r;
  logic isval_r, ret_r, conn_r;
  logic [6:0] code_r;
  logic [4:0] rate_r;
  ec_t ec_r;
  logic tx_valid_r;
  logic [7:0] tx_data_r;

  // Line collection; events wait for an empty line so replies never interleave
  wire is_term = rx_data == act_r[`I_RET]; // [RULE_22]
  wire is_bs = rx_data == act_r[`I_BS];
  assign rx_ready = st_r == ST_IDLE;
  assign ev_ready = st_r == ST_IDLE && len_r == 7'h00 && !rx_valid;
  wire rx_take = rx_valid && rx_ready;
  wire ev_take = ev_valid && ev_ready;
  wire at_ok = len_r >= `AT_LEN && up(line_r[0]) == "A" && up(line_r[1]) == "T"; // [RULE_09]
  wire [26:0] ev_rt = rate_tab(ev.rate);
  wire [6:0] evc = ev_code(ev.kind, ev_rt[26:20]);

  // Execution decode, one character per cycle
  wire ex = st_r == ST_EXEC;
  wire x_end = pos_r == len_r;
  wire [7:0] c = up(line_r[pos_r]);
  wire dig = c >= "0" && c <= "9";
  wire [3:0] dv = 4'(c - "0");
  wire [IW-1:0] widx = num_r[IW-1:0];
  wire [7:0] wval = val_r[7:0];
  wire num_bad = num_r >= 8'(NREG);
  wire [7:0] num_n = num_bad ? num_r : 8'(num_r * 8'h0a + {4'h0, dv});
  wire [11:0] val_n = val_r > 12'h0ff ? val_r : 12'(val_r * 12'h00a + {8'h00, dv});
  wire cmd_ok = c == " " || c == "S" || c == "&" || c == "Z" || (c == "0" && wz_r);
  wire commit = ex && ps_r == PS_VAL && (x_end || !dig);
  wire bad_wr = num_bad || val_r > {4'h0, rmax(widx)}; // [RULE_23]
  wire do_wr = commit && !bad_wr; // [RULE_02]
  wire rd_ok = ex && ps_r == PS_NUM && !x_end && c == "?" && !num_bad;
  wire do_store = ex && ps_r == PS_AMP && !x_end && c == "W"; // [RULE_05]
  wire do_fact = ex && ps_r == PS_AMP && !x_end && c == "F"; // [RULE_07]
  wire do_reload = ex && ps_r == PS_CMD && !x_end && c == "Z"; // [RULE_06]
  wire x_ok = ex && ps_r == PS_CMD && x_end; // [RULE_10]
  wire x_err = ex && ((ps_r == PS_CMD && !x_end && !cmd_ok) // [RULE_11]
    || (ps_r == PS_NUM && (x_end || !(dig || c == "=" || c == "?") || (c == "?" && num_bad)))
    || (ps_r == PS_AMP && (x_end || !(c == "W" || c == "F"))) || (commit && bad_wr)); // [RULE_23]
  wire ln_err = rx_take && is_term && (ovf_r || (len_r != 7'h00 && !at_ok)); // [RULE_11]
  wire res_go = ln_err || x_err || x_ok || ev_take;
  wire [6:0] res_code = ev_take ? evc : (ln_err || x_err) ? `RC_ERR : `RC_OK;

  // Reply composition: body, rate, suffix, return, line feed
  wire verb = act_r[`I_VERB][0]; // [RULE_24]
  wire [26:0] rt = rate_tab(rate_r);
  wire [131:0] wd = word(code_r);
  wire [67:0] td = tag(ec_r);
  wire [3:0] rlen = |rt[19:16] ? 4'h5 : |rt[15:12] ? 4'h4 : 4'h3;
  wire has_rate = !isval_r && verb && conn_r && rate_r != 5'h00;
  wire has_sfx = has_rate && ext_en_r && rate_r <= `R_EXT_LAST; // [RULE_19]
  wire two = code_r >= `RC_TWO;
  wire [3:0] len0 = isval_r ? `VAL_DIGITS : verb ? wd[131:128] : (two ? 4'h2 : 4'h1);
  wire [3:0] slen = seg_r == 3'h0 ? len0 : seg_r == 3'h1 ? (has_rate ? 4'(rlen + 4'h1) : 4'h0)
    : seg_r == 3'h2 ? (has_sfx ? td[67:64] : 4'h0) : 4'h1;
  wire [7:0] ch_val = idx_r == 4'h0 ? dchar(4'(vout_r / 8'd100))
    : idx_r == 4'h1 ? dchar(4'((vout_r / 8'd10) % 8'd10)) : dchar(4'(vout_r % 8'd10)); // [RULE_01]
  wire [7:0] ch_ters = (two && idx_r == 4'h0) ? dchar(4'(code_r / 7'd10)) : dchar(4'(code_r % 7'd10));
  wire [7:0] ch_word = wd[8 * (int'(wd[131:128]) - 1 - int'(idx_r)) +: 8];
  wire [7:0] ch_rate = idx_r == 4'h0 ? " " : dchar(rt[4 * (int'(rlen) - int'(idx_r)) +: 4]);
  wire [7:0] ch_tag = td[8 * (int'(td[67:64]) - 1 - int'(idx_r)) +: 8];
  wire [7:0] cur = seg_r == 3'h0 ? (isval_r ? ch_val : verb ? ch_word : ch_ters) // [RULE_24]
    : seg_r == 3'h1 ? ch_rate : seg_r == 3'h2 ? ch_tag
    : seg_r == 3'h3 ? act_r[`I_RET] : act_r[`I_LF];
  wire em = st_r == ST_EMIT;
  wire load = em && (!tx_valid_r || tx_ready) && idx_r < slen;
  wire step_seg = em && idx_r >= slen;
  assign tx_valid = tx_valid_r;
  assign tx_data = tx_data_r;

  // Line buffer; characters past the limit are dropped and flagged
  always_ff @(posedge aclk) begin
    if (rx_take && !is_term && !is_bs && len_r < 7'(LINE_LEN)) begin
      line_r[len_r] <= rx_data; // [RULE_21]
    end
  end

  // Active profile: restore, reload, then single register writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_r <= FACT_VEC;
    end else if (do_fact) begin
      act_r <= FACT_VEC; // [RULE_07]
    end else if (do_reload) begin
      act_r <= nv_valid_r ? nv_r : FACT_VEC; // [RULE_06]
    end else if (do_wr) begin
      act_r[widx] <= wval; // [RULE_02] [RULE_04]
    end
  end

  // Nonvolatile image has no reset; its valid flag marks a stored profile
  always_ff @(posedge aclk) begin
    if (do_store) begin
      nv_r <= act_r; // [RULE_05] [RULE_08]
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nv_valid_r <= 1'b0;
    end else if (do_store) begin
      nv_valid_r <= 1'b1;
    end
  end

  // Reply character register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_valid_r <= 1'b0;
      tx_data_r <= 8'h00;
    end else if (load) begin
      tx_valid_r <= 1'b1;
      tx_data_r <= cur;
    end else if (tx_ready) begin
      tx_valid_r <= 1'b0;
    end
  end

  // Sequencer: collect, execute left to right, emit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_IDLE;
      ps_r <= PS_CMD;
      {pos_r, len_r, ovf_r, wz_r, num_r, val_r, vout_r} <= '0;
      {seg_r, idx_r, isval_r, ret_r, conn_r, rate_r} <= '0;
      code_r <= `RC_OK;
      ec_r <= EC_NONE;
    end else begin
      if (st_r == ST_IDLE && rx_take) begin
        if (is_term) begin
          if (len_r != 7'h00 && at_ok && !ovf_r) begin
            st_r <= ST_EXEC;
            pos_r <= `AT_LEN; // [RULE_09]
            ps_r <= PS_CMD;
            wz_r <= 1'b0;
          end
        end else if (is_bs) begin
          if (len_r != 7'h00) len_r <= len_r - 7'h01; // [RULE_21]
        end else if (len_r < 7'(LINE_LEN)) begin
          len_r <= len_r + 7'h01;
        end else begin
          ovf_r <= 1'b1; // [RULE_11]
        end
      end
      if (ex) begin
        wz_r <= do_store || do_fact;
        if (!x_end && !commit && !x_err) pos_r <= pos_r + 7'h01; // [RULE_04]
        case (ps_r)
          PS_CMD: begin
            if (!x_end && c == "S") begin
              ps_r <= PS_NUM;
              num_r <= 8'h00;
            end else if (!x_end && c == "&") begin
              ps_r <= PS_AMP;
            end
          end
          PS_NUM: begin
            if (dig) begin
              num_r <= num_n;
            end else if (c == "=") begin
              ps_r <= PS_VAL;
              val_r <= 12'h000;
            end else begin
              ps_r <= PS_CMD;
            end
          end
          PS_VAL: begin
            if (commit) ps_r <= PS_CMD;
            else val_r <= val_n;
          end
          default: ps_r <= PS_CMD;
        endcase
      end
      if (em) begin
        if (step_seg) begin
          seg_r <= seg_r + 3'h1;
          idx_r <= 4'h0;
          if (seg_r == `SEG_LAST) begin
            st_r <= ret_r ? ST_EXEC : ST_IDLE;
            if (!ret_r) begin
              len_r <= 7'h00;
              ovf_r <= 1'b0;
            end
          end
        end else if (load) begin
          idx_r <= idx_r + 4'h1;
        end
      end
      // Launch a reply; a read resumes execution afterwards
      if (res_go || rd_ok) begin
        st_r <= ST_EMIT;
        seg_r <= 3'h0;
        idx_r <= 4'h0;
        isval_r <= rd_ok;
        ret_r <= rd_ok;
        vout_r <= act_r[widx]; // [RULE_01] [RULE_04]
        if (!rd_ok) begin
          code_r <= res_code;
          conn_r <= ev_take && ev.kind == EV_CONN; // [RULE_12]
          rate_r <= ev_take ? ev.rate : 5'h00;
          ec_r <= ev.ec;
        end
      end
    end
  end

  // AXI4-Lite slave; one write and one read at a time
  logic aw_h_r, w_h_r, bvalid_r, rvalid_r;
  logic [7:0] awa_r;
  logic [31:0] wd_r, rdata_r;
  logic [3:0] ws_r;
  logic [1:0] bresp_r, rresp_r;
  assign awready = !aw_h_r && !bvalid_r;
  assign wready = !w_h_r && !bvalid_r;
  assign arready = !rvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  wire wr_go = aw_h_r && w_h_r && !bvalid_r;
  wire [31:0] stat = {17'h0, len_r, nv_valid_r, code_r};
  wire [31:0] rd_mux = araddr == `A_CTRL ? {31'h0, ext_en_r} : araddr == `A_STAT ? stat
    : araddr == `A_SEL ? 32'(sel_r) : araddr == `A_DATA ? {24'h0, act_r[sel_r]} : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {aw_h_r, w_h_r, bvalid_r, ext_en_r, sel_r, awa_r, wd_r, ws_r} <= '0;
      bresp_r <= `RESP_OK;
    end else begin
      if (awvalid && awready) {aw_h_r, awa_r} <= {1'b1, awaddr};
      if (wvalid && wready) {w_h_r, wd_r, ws_r} <= {1'b1, wdata, wstrb};
      if (wr_go) begin
        {aw_h_r, w_h_r, bvalid_r} <= 3'b001;
        bresp_r <= addr_ok(awa_r) ? `RESP_OK : `RESP_ERR;
        if (awa_r == `A_CTRL && ws_r[0]) ext_en_r <= wd_r[0]; // [RULE_19]
        if (awa_r == `A_SEL && ws_r[0]) sel_r <= wd_r[IW-1:0];
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {rvalid_r, rdata_r} <= '0;
      rresp_r <= `RESP_OK;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= addr_ok(araddr) ? `RESP_OK : `RESP_ERR;
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_store;
    do_wr ##2 do_store;
  endsequence
  sequence s_wr_read;
    do_wr ##3 (rd_ok && widx == $past(widx, 3));
  endsequence
  a_read_digits: assert property (load && seg_r == 3'h0 && isval_r |=> tx_data_r inside {["0":"9"]}) // [RULE_01]
    else $error("read reply holds a non digit");
  a_assign_write: assert property (do_wr |=> act_r[$past(widx)] == $past(wval)) // [RULE_02]
    else $error("assignment not written");
  a_read_after: assert property (s_wr_read |=> vout_r == $past(wval, 4)) // [RULE_04]
    else $error("read missed the earlier write");
  a_store_copy: assert property (do_store |=> nv_valid_r && nv_r == $past(act_r)) // [RULE_05]
    else $error("store did not copy the profile");
  a_store_updated: assert property (s_wr_store |=> nv_r[$past(widx, 3)] == $past(wval, 3)) // [RULE_08]
    else $error("store lost an earlier assignment");
  a_reload_nv: assert property (do_reload && nv_valid_r |=> act_r == $past(nv_r)) // [RULE_06]
    else $error("reload did not take the stored profile");
  a_factory_load: assert property (do_fact |=> act_r == FACT_VEC) // [RULE_07]
    else $error("factory restore failed");
  a_prefix_error: assert property (rx_take && is_term && len_r != 7'h00 && !at_ok |=> em && code_r == `RC_ERR) // [RULE_09]
    else $error("line without attention prefix not refused");
  a_ok_code: assert property (x_ok |=> em && code_r == `RC_OK && !isval_r) // [RULE_10]
    else $error("clean line did not answer OK");
  a_overflow_err: assert property (rx_take && is_term && ovf_r |=> code_r == `RC_ERR ##1 em) // [RULE_11]
    else $error("overlong line did not answer ERROR");
  a_range_keep: assert property (commit && bad_wr |=> $stable(act_r) && code_r == `RC_ERR) // [RULE_23]
    else $error("bad assignment changed a register");
  a_event_code: assert property (ev_take && ev.kind == EV_RING |=> code_r == `RC_RING && em) // [RULE_13]
    else $error("ring event gave a wrong code");
  a_terse_form: assert property (load && seg_r == 3'h0 && !isval_r && !verb |=> tx_data_r inside {["0":"9"]}) // [RULE_24]
    else $error("terse reply is not numeric");
  a_line_cap: assert property (len_r <= 7'(LINE_LEN)) // [RULE_21]
    else $error("line buffer overran");
endmodule : at_cmd_interp
`default_nettype wire
